//--- hdl/pml_consts.vh
`ifndef PML_CONSTS_VH
`define PML_CONSTS_VH
`define PML_OFF_MBOX_ONE   8'h30
`define PML_OFF_MBOX_TWO   8'h34
`define PML_OFF_LOCK_CTRL  8'h60
`define PML_OFF_SERR_NMI   8'h64
`define PML_OFF_PCI_ENABLE 8'h74
`define PML_OFF_RETRY_CNT  8'h68
`define PML_OFF_IRQ_STAT   8'h6C
`define PML_BIT_LOCK_REQ   0
`define PML_BIT_TGT_UNLOCK 1
`define PML_BIT_RETRY_HIT  2
`define PML_BIT_ABORT      3
`define PML_BIT_NMI_NEGATE 4
`define PML_BIT_ADD_ON     1
`define PML_PCI_MBOX_TWO   12'h800
`define PML_RESET_WORD     32'h0000_0000
`define PML_RETRY_LIMIT    8'h10
`endif

//--- hdl/pml_mailbox_lock.v
`timescale 1ns/100ps
`include "pml_consts.vh"
module pml_mailbox_lock #(
  parameter [7:0] RETRY_LIMIT = `PML_RETRY_LIMIT
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        cpu_sel,
  input  wire        cpu_wr,
  input  wire [7:0]  cpu_addr,
  input  wire [31:0] cpu_wdata,
  output reg  [31:0] cpu_rdata_ff,
  output reg         cpu_refused_ff,
  input  wire        pci_clk,
  input  wire        serr_n,
  input  wire        frame_n,
  input  wire        lock_in_n,
  input  wire        pci_req,
  input  wire        pci_mem,
  input  wire        pci_wr,
  input  wire        pci_locked_cyc,
  input  wire [31:0] pci_addr,
  input  wire [31:0] pci_wdata,
  input  wire        memory_space_enable,
  input  wire [31:0] mbox_base,
  output reg  [31:0] pci_rdata_ff,
  output reg         pci_hit_ff,
  output reg         pci_retry_ff,
  input  wire        mst_start,
  input  wire [31:0] mst_target,
  input  wire        mst_done,
  input  wire        mst_retry,
  input  wire        mst_abort,
  output reg         lock_out_ff,
  output reg         mst_refused_ff,
  input  wire        refresh_req,
  output reg         refresh_go_ff,
  output reg         nmi_n_ff,
  output reg         mailbox_one_irq_flag_ff,
  output reg         mailbox_two_irq_flag_ff,
  output reg         target_locked_ff
);
  ////////////////////////////////////////////////////////////////////////////////
  reg  [5:0]  s1_ff;
  reg  [5:0]  s2_ff;
  reg         pclk_d_ff;
  reg  [31:0] mbox_ff [0:1];
  reg         lock_request_ff;
  reg         tgt_unlock_ff;
  reg         retry_limit_hit_ff;
  reg         abort_ff;
  reg         serr_bit_ff;
  reg         pci_en_ff;
  reg         add_on_ff;
  reg  [7:0]  retry_cnt_ff;
  reg  [31:0] locked_tgt_ff;
  reg         mst_busy_ff;
  reg         tgt_arm_ff;
  reg  [31:0] nxt_cpu_rdata;
  reg  [31:0] nxt_pci_rdata;
  reg         nxt_pci_hit;
  reg  [1:0]  pci_mb;
  reg  [1:0]  cpu_mb;
  wire        cpu_wr_go = cpu_go & cpu_wr;
  wire        mst_end   = mst_busy_ff & (mst_done | mst_abort);
  wire        pclk_rise = s2_ff[0] & ~pclk_d_ff;
  wire        serr_s    = ~s2_ff[1];
  wire        frame_s   = ~s2_ff[2];
  wire        lock_s    = ~s2_ff[3];
  wire        cpu_go    = cpu_sel & ~target_locked_ff;
  wire        pci_go    = pci_req & pclk_rise;
  wire        mbox_sel  = pci_mem & memory_space_enable;
  wire [31:0] off       = pci_addr - mbox_base;
  ////////////////////////////////////////////////////////////////////////////////
  // The link clock, error, frame and lock pins pass two flops before use; the link clock edge is found here.
  always @(posedge clk) begin
    if (rst) begin
      s1_ff     <= 6'h3F;
      s2_ff     <= 6'h3F;
      // Matches the reset value of the synchronised clock bit, so no false edge follows reset.
      pclk_d_ff <= 1'b1;
    end else begin
      s1_ff     <= {2'b11, lock_in_n, frame_n, serr_n, pci_clk};
      s2_ff     <= s1_ff;
      pclk_d_ff <= s2_ff[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @* begin
    pci_mb = 2'b00;
    cpu_mb = 2'b00;
    if (mbox_sel && off == 32'h0) pci_mb = 2'b01;
    if (mbox_sel && off == {20'h0, `PML_PCI_MBOX_TWO}) pci_mb = 2'b10;
    if (cpu_addr == `PML_OFF_MBOX_ONE) cpu_mb = 2'b01;
    if (cpu_addr == `PML_OFF_MBOX_TWO) cpu_mb = 2'b10;
    nxt_pci_hit   = pci_go && pci_mb != 2'b00 && ~(target_locked_ff && ~pci_locked_cyc);
    nxt_pci_rdata = pci_mb[1] ? mbox_ff[1] : (pci_mb[0] ? mbox_ff[0] : 32'h0);
    case (cpu_addr)
      `PML_OFF_MBOX_ONE:   nxt_cpu_rdata = mbox_ff[0];
      `PML_OFF_MBOX_TWO:   nxt_cpu_rdata = mbox_ff[1];
      `PML_OFF_LOCK_CTRL:  nxt_cpu_rdata = {28'h0, abort_ff, retry_limit_hit_ff,
                                            tgt_unlock_ff, lock_request_ff};
      `PML_OFF_SERR_NMI:   nxt_cpu_rdata = {31'h0, serr_bit_ff};
      `PML_OFF_RETRY_CNT:  nxt_cpu_rdata = {24'h0, retry_cnt_ff};
      `PML_OFF_IRQ_STAT:   nxt_cpu_rdata = {30'h0, mailbox_two_irq_flag_ff,
                                            mailbox_one_irq_flag_ff};
      `PML_OFF_PCI_ENABLE: nxt_cpu_rdata = {30'h0, add_on_ff, 1'b0};
      default:             nxt_cpu_rdata = 32'h0;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Mailboxes and their flags; the PCI set wins over a same-cycle CPU clear.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : mb
      always @(posedge clk) begin
        if (rst) begin
          mbox_ff[g] <= `PML_RESET_WORD;
        end else if (nxt_pci_hit && pci_mb[g] && pci_wr) begin
          mbox_ff[g] <= pci_wdata;
        end else if (cpu_go && cpu_wr && cpu_mb[g]) begin
          mbox_ff[g] <= cpu_wdata;
        end
      end
    end
  endgenerate
  always @(posedge clk) begin
    if (rst) begin
      mailbox_one_irq_flag_ff <= 1'b0;
      mailbox_two_irq_flag_ff <= 1'b0;
    end else begin
      if (nxt_pci_hit && pci_mb[0]) mailbox_one_irq_flag_ff <= 1'b1;
      else if (cpu_go && cpu_mb[0]) mailbox_one_irq_flag_ff <= 1'b0;
      if (nxt_pci_hit && pci_mb[1]) mailbox_two_irq_flag_ff <= 1'b1;
      else if (cpu_go && cpu_mb[1]) mailbox_two_irq_flag_ff <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rst) begin
      cpu_rdata_ff   <= 32'h0;
      cpu_refused_ff <= 1'b0;
      pci_rdata_ff   <= 32'h0;
      pci_hit_ff     <= 1'b0;
      pci_retry_ff   <= 1'b0;
      refresh_go_ff  <= 1'b0;
    end else begin
      cpu_rdata_ff   <= cpu_go ? nxt_cpu_rdata : 32'h0;
      cpu_refused_ff <= cpu_sel & target_locked_ff;
      pci_rdata_ff   <= nxt_pci_hit ? nxt_pci_rdata : 32'h0;
      pci_hit_ff     <= nxt_pci_hit;
      pci_retry_ff   <= pci_go & target_locked_ff & ~pci_locked_cyc;
      refresh_go_ff  <= refresh_req;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Control bits written by the CPU.
  always @(posedge clk) begin
    if (rst) begin
      lock_request_ff <= 1'b0;
      tgt_unlock_ff   <= 1'b0;
    end else begin
      if (cpu_wr_go && cpu_addr == `PML_OFF_LOCK_CTRL) begin
        lock_request_ff <= cpu_wdata[`PML_BIT_LOCK_REQ];
        tgt_unlock_ff   <= cpu_wdata[`PML_BIT_TGT_UNLOCK];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // The negate bit is a one-cycle strobe; it only acts in add-on mode.
  always @(posedge clk) begin
    if (rst) begin
      pci_en_ff <= 1'b0;
      add_on_ff <= 1'b0;
    end else begin
      pci_en_ff <= 1'b0;
      if (cpu_wr_go && cpu_addr == `PML_OFF_PCI_ENABLE) begin
        add_on_ff <= cpu_wdata[`PML_BIT_ADD_ON];
        pci_en_ff <= cpu_wdata[`PML_BIT_NMI_NEGATE];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // System error interrupt; a present error wins over a clear in the same cycle.
  always @(posedge clk) begin
    if (rst) begin
      serr_bit_ff <= 1'b0;
      nmi_n_ff    <= 1'b1;
    end else begin
      if (serr_s) begin
        serr_bit_ff <= 1'b1;
        nmi_n_ff    <= 1'b0;
      end else if (serr_bit_ff && cpu_wr_go && cpu_addr == `PML_OFF_SERR_NMI &&
                   cpu_wdata[0]) begin
        serr_bit_ff <= 1'b0;
        nmi_n_ff    <= 1'b1;
      end else if (pci_en_ff && add_on_ff) begin
        serr_bit_ff <= 1'b0;
        nmi_n_ff    <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Target lock: a locked cycle arms, the sampled lock pin then holds the device.
  always @(posedge clk) begin
    if (rst) begin
      target_locked_ff <= 1'b0;
      tgt_arm_ff       <= 1'b0;
    end else begin
      if (pci_go && pci_mb != 2'b00 && pci_locked_cyc && ~tgt_unlock_ff) begin
        tgt_arm_ff <= 1'b1;
      end
      if (tgt_arm_ff && lock_s) begin
        target_locked_ff <= 1'b1;
        tgt_arm_ff       <= 1'b0;
      end else if (~frame_s && ~lock_s) begin
        target_locked_ff <= 1'b0;
        tgt_arm_ff       <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Master side exclusive access.
  always @(posedge clk) begin
    if (rst) begin
      lock_out_ff    <= 1'b0;
      mst_busy_ff    <= 1'b0;
      mst_refused_ff <= 1'b0;
      locked_tgt_ff  <= 32'h0;
    end else begin
      mst_refused_ff <= 1'b0;
      if (mst_start && ~mst_busy_ff) begin
        if (lock_out_ff && mst_target != locked_tgt_ff) begin
          mst_refused_ff <= 1'b1;
        end else begin
          mst_busy_ff <= 1'b1;
          if (lock_request_ff && ~lock_s && ~lock_out_ff) begin
            lock_out_ff   <= 1'b1;
            locked_tgt_ff <= mst_target;
          end
        end
      end
      if (mst_end) begin
        mst_busy_ff <= 1'b0;
        if (~lock_request_ff) lock_out_ff <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Retry counting; a retry in the same cycle wins over a software clear.
  always @(posedge clk) begin
    if (rst) begin
      retry_cnt_ff       <= 8'h0;
      retry_limit_hit_ff <= 1'b0;
    end else begin
      if (mst_busy_ff && mst_retry && lock_out_ff) begin
        if (retry_cnt_ff == RETRY_LIMIT - 8'h1) retry_limit_hit_ff <= 1'b1;
        retry_cnt_ff <= retry_cnt_ff + 8'h1;
      end
      if (mst_end) begin
        retry_cnt_ff <= 8'h0;
      end
      if (cpu_wr_go && cpu_addr == `PML_OFF_LOCK_CTRL) begin
        if (~cpu_wdata[`PML_BIT_RETRY_HIT] && ~(mst_busy_ff && mst_retry)) begin
          retry_limit_hit_ff <= 1'b0;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Abort status; an abort in the same cycle wins over a software clear.
  always @(posedge clk) begin
    if (rst) begin
      abort_ff <= 1'b0;
    end else begin
      if (mst_busy_ff && mst_abort && lock_out_ff) begin
        abort_ff <= 1'b1;
      end else if (cpu_wr_go && cpu_addr == `PML_OFF_LOCK_CTRL &&
                   ~cpu_wdata[`PML_BIT_ABORT]) begin
        abort_ff <= 1'b0;
      end
    end
  end
endmodule

//--- sim/pml_chk_assertions.sv
`timescale 1ns/100ps
module pml_chk (
  input wire        clk,
  input wire        rst,
  input wire        cpu_sel,
  input wire        cpu_wr,
  input wire [7:0]  cpu_addr,
  input wire [31:0] cpu_rdata_ff,
  input wire        cpu_refused_ff,
  input wire        serr_n,
  input wire        pci_mem,
  input wire        memory_space_enable,
  input wire        pci_hit_ff,
  input wire        pci_retry_ff,
  input wire        mst_done,
  input wire        mst_abort,
  input wire        lock_out_ff,
  input wire        refresh_req,
  input wire        refresh_go_ff,
  input wire        nmi_n_ff,
  input wire        mailbox_one_irq_flag_ff,
  input wire        target_locked_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  serr_nmi_a: assert property (!serr_n [*4] |-> !nmi_n_ff)
    else $error("nmi not driven on system error");
  cpu_refuse_a: assert property (cpu_sel && target_locked_ff |=> cpu_refused_ff)
    else $error("cpu access not refused");
  lock_rsv_a: assert property (cpu_sel && !cpu_wr && cpu_addr == 8'h60 && !target_locked_ff
    |=> cpu_rdata_ff[31:4] == 28'h0) else $error("reserved bits not zero");
  flag_clr_a: assert property (cpu_sel && !target_locked_ff && cpu_addr == 8'h30
    |=> !mailbox_one_irq_flag_ff || pci_hit_ff) else $error("flag not cleared");
  flag_set_a: assert property ($rose(mailbox_one_irq_flag_ff) |-> pci_hit_ff)
    else $error("flag rose without pci hit");
  hit_mem_a: assert property (pci_hit_ff |-> $past(pci_mem) && $past(memory_space_enable))
    else $error("hit on non memory or disabled cycle");
  refresh_go_a: assert property (refresh_req |=> refresh_go_ff)
    else $error("refresh blocked");
  lock_drop_a: assert property ($fell(lock_out_ff) |-> $past(mst_done) || $past(mst_abort))
    else $error("lock dropped mid access");
  retry_lock_a: assert property (pci_retry_ff |-> $past(target_locked_ff))
    else $error("retry while not locked");
  cover property ($rose(target_locked_ff));
  cover property ($rose(lock_out_ff));
  cover property (pci_hit_ff);
endmodule
bind pml_mailbox_lock pml_chk pml_chk_i (.*);

//--- sim/pml_pci_agent.sv
`timescale 1ns/100ps
module pml_pci_agent (
  input  wire         clk,
  input  wire         pci_hit_ff,
  input  wire         pci_retry_ff,
  input  wire  [31:0] pci_rdata_ff,
  output logic        pci_clk,
  output logic        pci_req,
  output logic        pci_mem,
  output logic        pci_wr,
  output logic        pci_locked_cyc,
  output logic        frame_n,
  output logic        lock_in_n,
  output logic [31:0] pci_addr,
  output logic [31:0] pci_wdata
);
  logic        hit;
  logic        rty;
  logic [31:0] rd;
  initial begin
    {pci_req, pci_mem, pci_wr, pci_locked_cyc, hit, rty} = 6'h00;
    {frame_n, lock_in_n} = 2'h3;
    {pci_addr, pci_wdata, rd} = 96'h0;
    pci_clk = 1'b0;
    forever #62.5 pci_clk = ~pci_clk;
  end
  // Holds one request across exactly one link clock rise, then scrambles the lines.
  task automatic cyc(input logic m, w, k, input logic [31:0] a, d);
    @(negedge pci_clk);
    @(negedge clk);
    {pci_mem, pci_wr, pci_locked_cyc, pci_req, frame_n} = {m, w, k, 2'b10};
    {pci_addr, pci_wdata} = {a, d};
    lock_in_n = lock_in_n & ~k;
    {hit, rty} = 2'h0;
    repeat (15) begin
      @(posedge clk);
      if (pci_hit_ff) rd = pci_rdata_ff;
      {hit, rty} = {hit | pci_hit_ff, rty | pci_retry_ff};
    end
    @(negedge clk);
    {pci_req, frame_n} = 2'b01;
    {pci_addr, pci_wdata} = {~a, ~d};
  endtask
  task automatic unlock;
    @(negedge clk);
    lock_in_n = 1'b1;
  endtask
endmodule

//--- sim/pml_mailbox_lock_tb.sv
`timescale 1ns/100ps
module pml_mailbox_lock_tb;
  logic        clk, rst, cpu_sel, cpu_wr, serr_n, refresh_req, memory_space_enable, rf, mr;
  logic        mst_start, mst_done, mst_retry, mst_abort, pci_clk, pci_req, pci_mem, pci_wr;
  logic        pci_locked_cyc, frame_n, lock_in_n, cpu_refused_ff, pci_hit_ff, pci_retry_ff;
  logic        lock_out_ff, mst_refused_ff, refresh_go_ff, nmi_n_ff, target_locked_ff;
  logic        mailbox_one_irq_flag_ff, mailbox_two_irq_flag_ff;
  logic [7:0]  cpu_addr;
  logic [31:0] cpu_wdata, cpu_rdata_ff, pci_addr, pci_wdata, pci_rdata_ff, mst_target;
  logic [31:0] mbox_base, rd, wd, mb1;
  integer      failures, checked, seed;
  pml_mailbox_lock #(.RETRY_LIMIT(8'h04)) pml_mailbox_lock_i (.*);
  pml_pci_agent pml_pci_agent_i (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lock_view(input logic [1:0] st, input logic [31:0] w);
    return {28'h0, st, w[1:0]};
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    checked = checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cpu(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    {cpu_sel, cpu_wr, cpu_addr, cpu_wdata} = {1'b1, w, a, d};
    @(negedge clk);
    cpu_sel = 1'b0;
    {rd, rf} = {cpu_rdata_ff, cpu_refused_ff};
  endtask
  task automatic mp(input logic [3:0] v);
    @(negedge clk);
    {mst_start, mst_done, mst_retry, mst_abort} = v;
    @(negedge clk);
    {mst_start, mst_done, mst_retry, mst_abort, mr} = {4'h0, mst_refused_ff};
  endtask
  task automatic complete_run;
    $display("counts checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #900000;
    failures = failures + 1;
    complete_run;
  end
  initial begin
    {seed, failures, checked} = {32'h7B4E, 64'h0};
    {rst, serr_n, cpu_sel, cpu_wr, refresh_req, memory_space_enable} = 6'h30;
    {mst_start, mst_done, mst_retry, mst_abort, cpu_addr} = 12'h000;
    {cpu_wdata, mst_target, mbox_base} = 96'h0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 3; i++) begin
      cpu(1'b0, 8'h30 + 8'(i * 4) + 8'(i / 2 * 36), 32'h0);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      wd = $random(seed);
      cpu(1'b1, 8'h30 + 8'(i % 2 * 4), wd);
      cpu(1'b0, 8'h30 + 8'(i % 2 * 4), 32'h0);
      chk(rd, wd);
      if (i % 2 == 0) mb1 = wd;
    end
    cpu(1'b1, 8'h60, 32'hFFFFFFFF);
    cpu(1'b0, 8'h60, 32'h0);
    chk(rd, lock_view(2'h0, 32'hFFFFFFFF));
    cpu(1'b1, 8'h60, 32'h0);
    $display("register tests done");
    pml_pci_agent_i.cyc(1'b1, 1'b1, 1'b0, 32'h0, wd);
    chk({31'h0, pml_pci_agent_i.hit}, 32'h0);
    memory_space_enable = 1'b1;
    pml_pci_agent_i.cyc(1'b0, 1'b1, 1'b0, 32'h0, wd);
    chk({31'h0, pml_pci_agent_i.hit}, 32'h0);
    wd = $random(seed);
    pml_pci_agent_i.cyc(1'b1, 1'b1, 1'b0, 32'h800, wd);
    cpu(1'b0, 8'h6C, 32'h0);
    chk(rd, 32'h2);
    cpu(1'b0, 8'h34, 32'h0);
    chk(rd, wd);
    pml_pci_agent_i.cyc(1'b1, 1'b0, 1'b0, 32'h0, 32'h0);
    chk(pml_pci_agent_i.rd, mb1);
    cpu(1'b0, 8'h30, 32'h0);
    cpu(1'b0, 8'h6C, 32'h0);
    chk(rd, 32'h0);
    $display("pci mailbox tests done");
    serr_n = 1'b0;
    repeat (6) @(negedge clk);
    chk({31'h0, nmi_n_ff}, 32'h0);
    cpu(1'b0, 8'h64, 32'h0);
    chk(rd, 32'h1);
    serr_n = 1'b1;
    repeat (4) @(negedge clk);
    cpu(1'b1, 8'h64, 32'h1);
    cpu(1'b0, 8'h64, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, nmi_n_ff}, 32'h1);
    $display("system error tests done");
    for (int d = 1; d >= 0; d--) begin
      cpu(1'b1, 8'h60, {30'h0, d[0], 1'b0});
      pml_pci_agent_i.cyc(1'b1, 1'b0, 1'b1, 32'h0, 32'h0);
      repeat (6) @(negedge clk);
      chk({31'h0, target_locked_ff}, {31'h0, ~d[0]});
      if (d == 1) pml_pci_agent_i.unlock;
    end
    cpu(1'b0, 8'h30, 32'h0);
    chk({31'h0, rf}, 32'h1);
    pml_pci_agent_i.cyc(1'b1, 1'b1, 1'b0, 32'h0, 32'h0);
    chk({31'h0, pml_pci_agent_i.rty}, 32'h1);
    refresh_req = 1'b1;
    @(negedge clk);
    refresh_req = 1'b0;
    pml_pci_agent_i.unlock;
    repeat (6) @(negedge clk);
    chk({31'h0, target_locked_ff}, 32'h0);
    $display("target lock tests done");
    cpu(1'b1, 8'h60, 32'h1);
    mst_target = $random(seed);
    mp(4'h8);
    chk({31'h0, lock_out_ff}, 32'h1);
    mp(4'h4);
    mst_target = ~mst_target;
    mp(4'h8);
    chk({31'h0, mr}, 32'h1);
    mst_target = ~mst_target;
    mp(4'h8);
    repeat (4) mp(4'h2);
    cpu(1'b0, 8'h60, 32'h0);
    chk(rd, lock_view(2'h1, 32'h1));
    mp(4'h1);
    cpu(1'b0, 8'h60, 32'h0);
    chk(rd, lock_view(2'h3, 32'h1));
    cpu(1'b1, 8'h60, 32'h1);
    cpu(1'b0, 8'h60, 32'h0);
    chk(rd, lock_view(2'h0, 32'h1));
    mp(4'h8);
    cpu(1'b1, 8'h60, 32'h0);
    chk({31'h0, lock_out_ff}, 32'h1);
    mp(4'h4);
    chk({31'h0, lock_out_ff}, 32'h0);
    $display("master lock tests done");
    complete_run;
  end
endmodule
